//--- ddrsp_consts.svh
`ifndef DDRSP_CONSTS_SVH
`define DDRSP_CONSTS_SVH

// ----------------------------------------------------------------
// structure
// ----------------------------------------------------------------
`define DDRSP_NG 2
`define DDRSP_DW 8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DDRSP_A_CTRL 8'h00
`define DDRSP_A_DELAY 8'h04
`define DDRSP_A_STATUS 8'h08
`define DDRSP_A_WDATA 8'h0C
`define DDRSP_A_RDATA 8'h10

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define DDRSP_C_OE_EN 0
`define DDRSP_C_OE_REG 1
`define DDRSP_C_OD 2
`define DDRSP_C_MODE 3
`define DDRSP_C_PA_EN 5
`define DDRSP_C_NCLK 6
`define DDRSP_CTRL_W 7
`define DDRSP_CTRL_RST 7'h00
`define DDRSP_S_DLY 8

// ----------------------------------------------------------------
// delay chain figures
// ----------------------------------------------------------------
`define DDRSP_TAP_W 6
`define DDRSP_MAX_TAPS 63
`define DDRSP_TAP_PS 50
`define DDRSP_PHASE_DEG 90
`define DDRSP_DQS_MHZ 200
`define DDRSP_FIX_PS 600
`define DDRSP_DLL_TAPS \
   ((`DDRSP_PHASE_DEG * 1000000) / (360 * `DDRSP_DQS_MHZ * `DDRSP_TAP_PS))

`endif

//--- ddrsp_io.sv
`include "ddrsp_consts.svh"
// Contract
// - every data group owns one two-way strobe used for writes and reads.
// - data is sent and captured on both clock edges.
// - several strobes or strobe pairs share one delay setting source.
// - without the enable option the strobe drives permanently; else port gates.
// - optional register on the output enable, clocked by the output clock.
// - default mode inserts the requested phase shift as delay taps.
// - no-delay mode passes the strobe to the capture clock unshifted.
// - fixed mode takes 0-63 taps; a picosecond figure converts at build.
// - fixed taps are frequency independent and centre strobe in data eye.
// - with gating, a low strobe enable blocks false postamble capture edges.
// - negative-edge capture clock may come from the complement strobe.
// - active-high asynchronous clear for all registers; clock enable for the transmit and enable registers only.
// - strobe outputs may be open drain, driving low only.
module ddrsp_io #(
   parameter int FIX_PS = `DDRSP_FIX_PS
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // register controls
   input wire logic aclr,
   input wire logic clk_ena,
   // controller side
   input wire logic strobe_oe_req,
   input wire logic strobe_en,
   output logic [`DDRSP_NG-1:0] rx_valid,
   output logic [`DDRSP_TAP_W-1:0] delay_setting,
   // strobe pins
   input wire logic [`DDRSP_NG-1:0] dqs_i,
   output logic [`DDRSP_NG-1:0] dqs_o,
   output logic [`DDRSP_NG-1:0] dqs_oe,
   input wire logic [`DDRSP_NG-1:0] dqsn_i,
   output logic [`DDRSP_NG-1:0] dqsn_o,
   output logic [`DDRSP_NG-1:0] dqsn_oe,
   // data pins
   input wire logic [`DDRSP_NG*`DDRSP_DW-1:0] dq_i,
   output logic [`DDRSP_NG*`DDRSP_DW-1:0] dq_o,
   output logic [`DDRSP_NG*`DDRSP_DW-1:0] dq_oe,
   // capture clocks
   output logic [`DDRSP_NG-1:0] cap_clk,
   output logic [`DDRSP_NG-1:0] neg_clk
);
   localparam int NG = `DDRSP_NG;
   localparam int DW = `DDRSP_DW;
   localparam int FIX_RAW = FIX_PS / `DDRSP_TAP_PS;
   localparam int FIX_TAPS = (FIX_RAW > `DDRSP_MAX_TAPS) ?
      `DDRSP_MAX_TAPS : FIX_RAW;
   localparam int DLL_TAPS = (`DDRSP_DLL_TAPS > `DDRSP_MAX_TAPS) ?
      `DDRSP_MAX_TAPS : `DDRSP_DLL_TAPS;
   localparam logic [`DDRSP_TAP_W-1:0] FIX_RST = FIX_TAPS[5:0];
   localparam logic [`DDRSP_TAP_W-1:0] DLL_SET = DLL_TAPS[5:0];

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic logic ddrsp_mapped(input logic [7:0] a);
      ddrsp_mapped = (a == `DDRSP_A_CTRL) || (a == `DDRSP_A_DELAY) ||
         (a == `DDRSP_A_STATUS) || (a == `DDRSP_A_WDATA) ||
         (a == `DDRSP_A_RDATA);
   endfunction

   logic rst_n;
   logic acc;
   logic wr;
   logic [`DDRSP_CTRL_W-1:0] ctrl_ff;
   logic [`DDRSP_TAP_W-1:0] delay_ff;
   logic [`DDRSP_TAP_W-1:0] dset_ff;
   logic [`DDRSP_TAP_W-1:0] nxt_dset;
   logic [31:0] wdata_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [NG-1:0] seen_ff;
   logic [2*DW-1:0] rdata_ff [NG];
   logic [NG*DW-1:0] tx_rise_ff;
   logic [NG*DW-1:0] tx_fall_ff;
   logic oe_reg_ff;
   logic oe_src;
   logic oe_final;
   logic strobe_val;
   logic ctrl_oe_en;
   logic ctrl_oe_reg;
   logic ctrl_od;
   logic ctrl_pa_en;
   logic ctrl_nclk;
   ddrsp_pkg::ddrsp_dmode_type mode;

   // clear pin and bus reset share every register
   assign rst_n = presetn & ~aclr;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign pready = 1'b1;
   assign pslverr = acc & ~ddrsp_mapped(paddr);
   assign prdata = prdata_ff;

   assign ctrl_oe_en = ctrl_ff[`DDRSP_C_OE_EN];
   assign ctrl_oe_reg = ctrl_ff[`DDRSP_C_OE_REG];
   assign ctrl_od = ctrl_ff[`DDRSP_C_OD];
   assign ctrl_pa_en = ctrl_ff[`DDRSP_C_PA_EN];
   assign ctrl_nclk = ctrl_ff[`DDRSP_C_NCLK];
   assign mode = ddrsp_pkg::ddrsp_dmode_type'(ctrl_ff[4:3]);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // configuration registers
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `DDRSP_CTRL_RST;
         delay_ff <= FIX_RST;
         wdata_ff <= 32'h0000_0000;
      end else if (wr) begin
         if (paddr == `DDRSP_A_CTRL) begin
            ctrl_ff <= pwdata[`DDRSP_CTRL_W-1:0];
         end
         if (paddr == `DDRSP_A_DELAY) begin
            delay_ff <= pwdata[`DDRSP_TAP_W-1:0];
         end
         if (paddr == `DDRSP_A_WDATA) begin
            wdata_ff <= pwdata;
         end
      end
   end

   // read data latched in the setup cycle, stable through access
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         `DDRSP_A_CTRL: begin
            nxt_prdata[`DDRSP_CTRL_W-1:0] = ctrl_ff;
         end
         `DDRSP_A_DELAY: begin
            nxt_prdata[`DDRSP_TAP_W-1:0] = delay_ff;
         end
         `DDRSP_A_STATUS: begin
            nxt_prdata[NG-1:0] = seen_ff;
            nxt_prdata[`DDRSP_S_DLY+:`DDRSP_TAP_W] = dset_ff;
         end
         `DDRSP_A_WDATA: begin
            nxt_prdata = wdata_ff;
         end
         `DDRSP_A_RDATA: begin
            nxt_prdata = {rdata_ff[1], rdata_ff[0]};
         end
         default: begin
            nxt_prdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // ----------------------------------------------------------------
   // shared delay setting for all strobes
   // ----------------------------------------------------------------
   // one setting feeds every strobe delay cell, like a common loop
   always_comb begin
      case (mode)
         ddrsp_pkg::DDRSP_DLY_DLL: begin
            nxt_dset = DLL_SET;
         end
         ddrsp_pkg::DDRSP_DLY_FIXED: begin
            nxt_dset = delay_ff;
         end
         ddrsp_pkg::DDRSP_DLY_NONE: begin
            nxt_dset = '0;
         end
         default: begin
            nxt_dset = '0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         dset_ff <= DLL_SET;
      end else begin
         dset_ff <= nxt_dset;
      end
   end

   assign delay_setting = dset_ff;

   // ----------------------------------------------------------------
   // transmit path
   // ----------------------------------------------------------------
   // word halves for the two clock phases, held while enable is low
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_rise_ff <= '0;
         tx_fall_ff <= '0;
      end else if (clk_ena) begin
         tx_rise_ff <= {wdata_ff[23:16], wdata_ff[7:0]};
         tx_fall_ff <= {wdata_ff[31:24], wdata_ff[15:8]};
      end
   end

   // output enable source and optional register
   assign oe_src = ctrl_oe_en ? strobe_oe_req : 1'b1;

   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         oe_reg_ff <= 1'b0;
      end else if (clk_ena) begin
         oe_reg_ff <= oe_src;
      end
   end

   assign oe_final = ctrl_oe_reg ? oe_reg_ff : oe_src;

   // clock-level mux: high phase sends rise half, low phase fall half
   assign strobe_val = pclk;
   assign dq_o = pclk ? tx_rise_ff : tx_fall_ff;
   assign dq_oe = {(NG*DW){oe_final}};

   // one strobe pair per group, same pins for both directions
   generate
      for (genvar g = 0; g < NG; g++) begin : g_pins
         // open drain pulls low only, so pad floats on a high level
         assign dqs_o[g] = ctrl_od ? 1'b0 : strobe_val;
         assign dqs_oe[g] = ctrl_od ? (oe_final & ~strobe_val) :
            oe_final;
         assign dqsn_o[g] = ctrl_od ? 1'b0 : ~strobe_val;
         assign dqsn_oe[g] = ctrl_od ? (oe_final & strobe_val) :
            oe_final;
      end
   endgenerate

   // ----------------------------------------------------------------
   // receive path, strobe domain, and crossing to pclk
   // ----------------------------------------------------------------
   // captured pairs are only sampled once per toggle; a strobe much
   // faster than pclk overwrites pairs before they are taken
   generate
      for (genvar g = 0; g < NG; g++) begin : g_rx
         logic gate_ff;
         logic gate;
         logic [DW-1:0] rise_ff;
         logic [DW-1:0] fall_ff;
         logic tog_ff;
         logic tog_s;
         logic tog_prev_ff;
         logic ev;

         // last falling edge with enable low closes the gate
         always_ff @(negedge dqs_i[g] or negedge rst_n) begin
            if (!rst_n) begin
               gate_ff <= 1'b1;
            end else begin
               gate_ff <= strobe_en;
            end
         end

         // enable high reopens at once, before the next preamble
         assign gate = ~ctrl_pa_en | strobe_en | gate_ff;
         assign cap_clk[g] = dqs_i[g] & gate;
         assign neg_clk[g] = ctrl_nclk ? (dqsn_i[g] & gate) :
            ~cap_clk[g];

         always_ff @(posedge cap_clk[g] or negedge rst_n) begin
            if (!rst_n) begin
               rise_ff <= '0;
            end else begin
               rise_ff <= dq_i[g*DW+:DW];
            end
         end

         // falling-edge half completes a pair and flips the toggle
         always_ff @(posedge neg_clk[g] or negedge rst_n) begin
            if (!rst_n) begin
               fall_ff <= '0;
               tog_ff <= 1'b0;
            end else begin
               fall_ff <= dq_i[g*DW+:DW];
               tog_ff <= ~tog_ff;
            end
         end

         ddrsp_sync u_sync (
            .pclk(pclk),
            .rst_n(rst_n),
            .d(tog_ff),
            .q(tog_s)
         );

         assign ev = tog_s ^ tog_prev_ff;
         assign rx_valid[g] = ev;

         always_ff @(posedge pclk or negedge rst_n) begin
            if (!rst_n) begin
               tog_prev_ff <= 1'b0;
               rdata_ff[g] <= '0;
            end else begin
               tog_prev_ff <= tog_s;
               if (ev) begin
                  rdata_ff[g] <= {fall_ff, rise_ff};
               end
            end
         end

         // sticky arrival flag, a new pair beats a write-one clear
         always_ff @(posedge pclk or negedge rst_n) begin
            if (!rst_n) begin
               seen_ff[g] <= 1'b0;
            end else if (ev) begin
               seen_ff[g] <= 1'b1;
            end else if (wr && paddr == `DDRSP_A_STATUS && pwdata[g]) begin
               seen_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_perm_drive;
      @(posedge pclk) disable iff (!rst_n)
      (!ctrl_oe_en && !ctrl_od) |-> (dqs_oe == {NG{1'b1}});
   endproperty
   a_perm_drive: assert property (p_perm_drive)
      else $error("strobe not driven permanently");

   property p_oe_reg;
      @(posedge pclk) disable iff (!rst_n)
      (clk_ena && ctrl_oe_reg) ##1 ctrl_oe_reg |->
         oe_final == $past(oe_src);
   endproperty
   a_oe_reg: assert property (p_oe_reg)
      else $error("registered enable lags wrong");

   property p_dll;
      @(posedge pclk) disable iff (!rst_n)
      (mode == ddrsp_pkg::DDRSP_DLY_DLL) |=> (delay_setting == DLL_SET);
   endproperty
   a_dll: assert property (p_dll)
      else $error("phase-shift taps wrong");

   property p_nodelay;
      @(posedge pclk) disable iff (!rst_n)
      (mode == ddrsp_pkg::DDRSP_DLY_NONE) |=> (delay_setting == '0);
   endproperty
   a_nodelay: assert property (p_nodelay)
      else $error("delay added in bypass mode");

   property p_fixed;
      @(posedge pclk) disable iff (!rst_n)
      (mode == ddrsp_pkg::DDRSP_DLY_FIXED) |=>
         (delay_setting == $past(delay_ff));
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed taps not applied");

   property p_od;
      @(posedge pclk) disable iff (!rst_n)
      ctrl_od |-> (dqs_o == '0) && (dqsn_o == '0);
   endproperty
   a_od: assert property (p_od)
      else $error("open drain drives high");

   property p_gate;
      @(posedge pclk) disable iff (!rst_n)
      (ctrl_pa_en && !strobe_en && !g_rx[0].gate_ff) |->
         !cap_clk[0];
   endproperty
   a_gate: assert property (p_gate)
      else $error("capture clock not blocked");

   property p_clr;
      @(posedge pclk) disable iff (!presetn)
      aclr |-> (tx_rise_ff == '0) && (ctrl_ff == `DDRSP_CTRL_RST);
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear did not act");

   property p_hold;
      @(posedge pclk) disable iff (!rst_n)
      !clk_ena ##1 1'b1 |-> $stable(tx_rise_ff) && $stable(oe_reg_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("registers moved without enable");
endmodule

//--- ddrsp_mem_model.sv
// ----------------------------------------------------------------
// read side of the external memory: strobe bursts on the link clock
// ----------------------------------------------------------------
module ddrsp_mem_model (
   // link clock and burst request
   input wire logic lclk,
   input wire logic go,
   input wire logic [31:0] rd_word,
   // pad drive toward the block
   output logic [1:0] m_dqs,
   output logic [1:0] m_dqsn,
   output logic [15:0] m_dq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rel;
   initial begin
      m_dqs = 2'b00;
      m_dqsn = 2'b11;
      m_dq = 16'h0000;
      rel = 1'b0;
   end
   // the word's pair sent twice, then one released pair; each phase lasts
   // seven and a half link clocks, since a pair must cross to pclk before the next
   // one lands; strobe lags data by 8 ns, the delay cells being a tap
   // count only
   always @(posedge lclk) begin
      if (go) begin
         for (int b = 0; b < 3; b++) begin
            rel = (b == 2);
            m_dq <= rel ? ~m_dq : {rd_word[23:16], rd_word[7:0]};
            #8 m_dqs <= 2'b11;
            m_dqsn <= 2'b00;
            repeat (8) @(negedge lclk);
            m_dq <= rel ? ~m_dq : {rd_word[31:24], rd_word[15:8]};
            #8 m_dqs <= 2'b00;
            m_dqsn <= 2'b11;
            repeat (8) @(posedge lclk);
         end
      end else begin
         // released data bits wander; strobe parked low as next preamble
         m_dq <= ~m_dq;
      end
   end
endmodule

//--- ddrsp_pkg.sv
package ddrsp_pkg;
   // source of the read strobe delay setting
   typedef enum logic [1:0] {
      DDRSP_DLY_DLL = 2'b00,
      DDRSP_DLY_NONE = 2'b01,
      DDRSP_DLY_FIXED = 2'b10
   } ddrsp_dmode_type;
endpackage

//--- ddrsp_sync.sv
// ----------------------------------------------------------------
// three-stage level synchroniser, change accepted when stages agree
// ----------------------------------------------------------------
module ddrsp_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic rst_n,
   // level in and out
   input wire logic d,
   output logic q
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic q_ff;

   // shift chain; only s2 looks at s1
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // settled value follows once stages two and three agree
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         q_ff <= s3_ff;
      end
   end

   assign q = q_ff;
endmodule

//--- tb_ddrsp_io.sv
`include "ddrsp_consts.svh"
module tb_ddrsp_io;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, lclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic aclr, clk_ena, strobe_oe_req, strobe_en, go;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_word, q, wd;
   logic [1:0] rx_valid, dqs_i, dqs_o, dqs_oe, dqsn_i, dqsn_o, dqsn_oe;
   logic [1:0] cap_clk, neg_clk, m_dqs, m_dqsn;
   logic [5:0] delay_setting;
   logic [15:0] dq_i, dq_o, dq_oe, m_dq;
   logic err;
   int failures, check_count, cyc, pulses;
   logic [31:0] words [4];
   logic [5:0] taps [4];
   // ----------------------------------------------------------------
   // pad wires resolved from both drivers
   // ----------------------------------------------------------------
   assign dqs_i = (dqs_oe & dqs_o) | (~dqs_oe & m_dqs);
   assign dqsn_i = (dqsn_oe & dqsn_o) | (~dqsn_oe & m_dqsn);
   assign dq_i = (dq_oe & dq_o) | (~dq_oe & m_dq);
   ddrsp_io #(.FIX_PS(300)) u_ddrsp_io (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .aclr(aclr), .clk_ena(clk_ena), .strobe_oe_req(strobe_oe_req),
      .strobe_en(strobe_en), .rx_valid(rx_valid),
      .delay_setting(delay_setting), .dqs_i(dqs_i), .dqs_o(dqs_o),
      .dqs_oe(dqs_oe), .dqsn_i(dqsn_i), .dqsn_o(dqsn_o), .dqsn_oe(dqsn_oe),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .cap_clk(cap_clk),
      .neg_clk(neg_clk));
   ddrsp_mem_model u_ddrsp_mem_model (.lclk(lclk), .go(go),
      .rd_word(rd_word), .m_dqs(m_dqs), .m_dqsn(m_dqsn), .m_dq(m_dq));
   // ----------------------------------------------------------------
   // clocks, timeout and reporting
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // link clock phase chosen so its edges never meet pclk edges
   initial begin
      lclk = 1'b0;
      #7;
      forever #16 lclk = ~lclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         give_verdict();
      end
   end
   // arrival pulses of both groups, looked at mid-cycle
   always @(negedge pclk) begin
      pulses += rx_valid[0] + rx_valid[1];
   end
   task automatic give_verdict();
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits on pready, never assumes a count
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // enable stays up past the first fall, drops before the second one
   // and rises again only after the released beat has gone by
   task automatic mem_read(input logic [31:0] w);
      @(posedge pclk);
      pulses = 0;
      rd_word <= w;
      go <= 1'b1;
      strobe_en <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      strobe_en <= 1'b0;
      repeat (9) @(posedge pclk);
      strobe_en <= 1'b1;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, aclr, go} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rd_word = 32'h0;
      clk_ena = 1'b1;
      strobe_oe_req = 1'b0;
      strobe_en = 1'b1;
      presetn = 1'b0;
      words = '{32'hA1B2C3D4, 32'h5E6F7081, 32'h92A3B4C5, 32'h0F1E2D3C};
      taps = '{6'h19, 6'h00, 6'h3F, 6'h00};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `DDRSP_A_CTRL, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, `DDRSP_A_DELAY, 32'h0);
      chk(q, 32'h6);
      chk({26'h0, delay_setting}, 32'h19);
      apb(1'b0, 8'h14, 32'h0);
      chk({q[30:0], err}, 32'h1);
      // transmit on both phases, strobe always driven by default
      wd = 32'hA55A3CC3;
      apb(1'b1, `DDRSP_A_WDATA, wd);
      repeat (2) @(posedge pclk);
      #20 chk({dq_o, dq_oe}, {wd[23:16], wd[7:0], 16'hFFFF});
      chk({dqs_o, dqs_oe, dqsn_o}, {2'b11, 2'b11, 2'b00});
      @(negedge pclk);
      #20 chk({16'h0, dq_o}, {16'h0, wd[31:24], wd[15:8]});
      @(posedge pclk);
      clk_ena <= 1'b0;
      apb(1'b1, `DDRSP_A_WDATA, 32'h12345678);
      repeat (2) @(posedge pclk);
      #20 chk({16'h0, dq_o}, {16'h0, wd[23:16], wd[7:0]});
      @(posedge pclk);
      clk_ena <= 1'b1;
      // enable port, plain then registered
      apb(1'b1, `DDRSP_A_CTRL, 32'h1);
      #20 chk({30'h0, dqs_oe}, 32'h0);
      @(posedge pclk);
      strobe_oe_req <= 1'b1;
      #20 chk({14'h0, dqs_oe, dq_oe}, {14'h0, 2'b11, 16'hFFFF});
      apb(1'b1, `DDRSP_A_CTRL, 32'h3);
      @(posedge pclk);
      strobe_oe_req <= 1'b0;
      #20 chk({30'h0, dqs_oe}, 32'h3);
      @(posedge pclk);
      #20 chk({30'h0, dqs_oe}, 32'h0);
      // open drain: released while high, pulled low while low
      apb(1'b1, `DDRSP_A_CTRL, 32'h4);
      @(posedge pclk);
      #20 chk({dqs_o, dqs_oe, dqsn_oe}, {2'b00, 2'b00, 2'b11});
      @(negedge pclk);
      #20 chk({dqs_o, dqs_oe, dqsn_oe}, {2'b00, 2'b11, 2'b00});
      // every delay mode, gated reads, complement clock in fixed mode
      for (int m = 0; m < 4; m++) begin
         if (m == 2)
            apb(1'b1, `DDRSP_A_DELAY, 32'h3F);
         apb(1'b1, `DDRSP_A_CTRL, 32'h21 | (m << 3) | ((m == 2) << 6));
         apb(1'b1, `DDRSP_A_STATUS, 32'h3);
         chk({26'h0, delay_setting}, {26'h0, taps[m]});
         mem_read(words[m]);
         chk(pulses, 32'h4);
         apb(1'b0, `DDRSP_A_RDATA, 32'h0);
         chk(q, words[m]);
         apb(1'b0, `DDRSP_A_STATUS, 32'h0);
         chk(q & 32'h3F03, {18'h0, taps[m], 8'h03});
         apb(1'b1, `DDRSP_A_STATUS, 32'h3);
         apb(1'b0, `DDRSP_A_STATUS, 32'h0);
         chk(q & 32'h3, 32'h0);
      end
      // asynchronous clear returns control to defaults
      @(posedge pclk);
      aclr <= 1'b1;
      repeat (2) @(posedge pclk);
      aclr <= 1'b0;
      apb(1'b0, `DDRSP_A_CTRL, 32'h0);
      chk(q, 32'h0);
      give_verdict();
   end
endmodule
